// ### rtl/acs_pkg.sv
// Notes on behaviour
// - Converter clock divides core clock by 8/4/16/32
// - Acquisition lasts 1 to 4 converter clocks
// - Conversion lasts exactly fifteen converter clocks
// - Start requests synchronised to converter clock first
// - Temperature channel forces divide-32, four acquisition cycles
// - Single shot runs once, self-clears after result
// - Repeat bit runs back-to-back conversions until cleared
// - Enabled external start begins on rising edge
// - Enabled timer overflow starts a conversion
// - Config A bit 6 selects external reference
// - Config B bit 6 enables fast capture
// - Serial send overlaps next conversion when fast
// - Fast capture sends channel then result, MSB first
// - Fast capture suspends port 3 and drives the serial port
// - Busy flag in config C bit 7
package acs_pkg;
    localparam int DATA_W = 12;
    localparam int CHAN_W = 4;
    localparam int WORD_W = DATA_W + CHAN_W;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFS_CFG_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CFG_B = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CFG_C = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_TX = 8'h10;

    localparam int A_EXT_EN = 0;
    localparam int A_TMR_EN = 1;
    localparam int A_ACQ_LO = 2;
    localparam int A_DIV_LO = 4;
    localparam int A_EXT_REF = 6;
    localparam int B_CHAN_LO = 0;
    localparam int B_SINGLE = 4;
    localparam int B_REPEAT = 5;
    localparam int B_FAST = 6;
    localparam int C_BUSY = 7;

    localparam logic [7:0] CFG_A_RST = 8'h00;
    localparam logic [7:0] CFG_B_RST = 8'h00;

    localparam logic [3:0] CONV_CYCLES = 4'hf;
    localparam logic [CHAN_W-1:0] TEMP_CHAN = 4'h8;
    localparam logic [1:0] TEMP_ACQ = 2'h3;
    localparam logic [1:0] DIV_SEL_32 = 2'h3;
    localparam logic [5:0] DIV_RATIO_0 = 6'h08;
    localparam logic [5:0] DIV_RATIO_1 = 6'h04;
    localparam logic [5:0] DIV_RATIO_2 = 6'h10;
    localparam logic [5:0] DIV_RATIO_3 = 6'h20;

    localparam int CLK_MHZ = 20;
    localparam int EXT_START_MIN_NS = 100;
    localparam int EXT_START_MIN_CYC = (EXT_START_MIN_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        ACS_IDLE = 4'h1,
        ACS_SYNC = 4'h2,
        ACS_ACQ = 4'h4,
        ACS_CONV = 4'h8
    } acs_state_t;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [DATA_W-1:0] data;
    } acs_sample_t;

    function automatic logic [5:0] acs_div_ratio(input logic [1:0] sel);
        case (sel)
            2'h0: acs_div_ratio = DIV_RATIO_0;
            2'h1: acs_div_ratio = DIV_RATIO_1;
            2'h2: acs_div_ratio = DIV_RATIO_2;
            default: acs_div_ratio = DIV_RATIO_3;
        endcase
    endfunction
endpackage

// ### rtl/acs_clk_div.sv
`timescale 1ns/1ns
`default_nettype none
module acs_clk_div (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] div_sel,
    output logic tick
);
    import acs_pkg::*;

    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } acs_div_st_t;

    acs_div_st_t s_r;
    acs_div_st_t s_nxt;
    logic [5:0] ratio;

    assign ratio = acs_div_ratio(div_sel);
    assign tick = s_r.tick;

    always_comb begin
        s_nxt = s_r;
        // Compare with >= so a smaller ratio chosen mid-count recovers at once
        if (s_r.cnt >= ratio - 6'h01) begin
            s_nxt.cnt = 6'h00;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 6'h01;
            s_nxt.tick = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/acs_capture_tx.sv
`timescale 1ns/1ns
`default_nettype none
module acs_capture_tx #(
    parameter int WORD = 16,
    parameter int HALF_DIV = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WORD-1:0] word,
    output logic sclk,
    output logic mosi,
    output logic active
);
    typedef struct packed {
        logic [WORD-1:0] sh;
        logic [7:0] bits;
        logic [7:0] div;
        logic sclk;
        logic mosi;
        logic active;
    } acs_tx_st_t;

    acs_tx_st_t s_r;
    acs_tx_st_t s_nxt;

    assign sclk = s_r.sclk;
    assign mosi = s_r.mosi;
    assign active = s_r.active;

    always_comb begin
        s_nxt = s_r;
        // A new load restarts the shifter; finishing in time is up to software
        if (load) begin
            s_nxt.sh = word;
            s_nxt.mosi = word[WORD-1];
            s_nxt.bits = 8'(WORD);
            s_nxt.div = 8'h00;
            s_nxt.sclk = 1'b0;
            s_nxt.active = 1'b1;
        end else if (s_r.active) begin
            if (s_r.div == 8'(HALF_DIV - 1)) begin
                s_nxt.div = 8'h00;
                if (!s_r.sclk) begin
                    s_nxt.sclk = 1'b1;
                end else begin
                    s_nxt.sclk = 1'b0;
                    s_nxt.bits = s_r.bits - 8'h01;
                    if (s_r.bits == 8'h01) begin
                        s_nxt.active = 1'b0;
                        s_nxt.mosi = 1'b0;
                    end else begin
                        s_nxt.sh = {s_r.sh[WORD-2:0], 1'b0};
                        s_nxt.mosi = s_r.sh[WORD-2];
                    end
                end
            end else begin
                s_nxt.div = s_r.div + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/acs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer #(
    parameter int SER_HALF_DIV = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [acs_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_start_n,
    input wire logic timer_ovf,
    input wire logic [acs_pkg::DATA_W-1:0] sar_result,
    output logic [acs_pkg::CHAN_W-1:0] chan_sel,
    output logic track,
    output logic hold_convert,
    output logic conv_tick,
    output logic ext_ref_sel,
    output logic busy,
    output logic port3_suspend,
    output logic ser_sclk,
    output logic ser_mosi,
    output logic ser_active
);
    import acs_pkg::*;

    typedef struct packed {
        logic [7:0] cfg_a;
        logic [7:0] cfg_b;
        acs_sample_t result;
        acs_sample_t tx_word;
        acs_state_t state;
        logic [3:0] cnt;
        logic pend;
        logic ext_prev;
        logic done;
        logic load;
        logic busy;
        logic track;
        logic hold;
        logic waitreq;
        logic [31:0] rdata;
    } acs_seq_st_t;

    acs_seq_st_t s_r;
    acs_seq_st_t s_nxt;
    logic tick;
    logic is_temp;
    logic [1:0] div_eff;
    logic [1:0] acq_eff;
    logic wr_ok;
    logic ext_rise;

    // Temperature channel overrides both timing fields
    assign is_temp = s_r.cfg_b[B_CHAN_LO +: CHAN_W] == TEMP_CHAN;
    assign div_eff = is_temp ? DIV_SEL_32 : s_r.cfg_a[A_DIV_LO +: 2];
    assign acq_eff = is_temp ? TEMP_ACQ : s_r.cfg_a[A_ACQ_LO +: 2];
    assign wr_ok = avs_write && !s_r.waitreq && avs_byteenable[0];
    assign ext_rise = s_r.cfg_a[A_EXT_EN] && !s_r.ext_prev && ext_start_n;

    acs_clk_div u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .div_sel(div_eff),
        .tick(tick)
    );

    acs_capture_tx #(
        .WORD(WORD_W),
        .HALF_DIV(SER_HALF_DIV)
    ) u_tx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(s_r.load),
        .word(s_r.tx_word),
        .sclk(ser_sclk),
        .mosi(ser_mosi),
        .active(ser_active)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.ext_prev = ext_start_n;
        s_nxt.done = 1'b0;
        s_nxt.load = 1'b0;

        case (s_r.state)
            ACS_IDLE: begin
                if (s_r.cfg_b[B_SINGLE] || s_r.cfg_b[B_REPEAT] || s_r.pend) begin
                    s_nxt.state = ACS_SYNC;
                    s_nxt.pend = 1'b0;
                end
            end
            ACS_SYNC: begin
                if (tick) begin
                    s_nxt.state = ACS_ACQ;
                    s_nxt.cnt = 4'h0;
                end
            end
            ACS_ACQ: begin
                if (tick) begin
                    if (s_r.cnt == {2'b00, acq_eff}) begin
                        s_nxt.state = ACS_CONV;
                        s_nxt.cnt = 4'h0;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
            end
            ACS_CONV: begin
                if (tick) begin
                    if (s_r.cnt == CONV_CYCLES - 4'h1) begin
                        s_nxt.done = 1'b1;
                        s_nxt.result.chan = s_r.cfg_b[B_CHAN_LO +: CHAN_W];
                        s_nxt.result.data = sar_result;
                        s_nxt.cfg_b[B_SINGLE] = 1'b0;
                        if (s_r.cfg_b[B_FAST]) begin
                            s_nxt.tx_word.chan = s_r.cfg_b[B_CHAN_LO +: CHAN_W];
                            s_nxt.tx_word.data = sar_result;
                            s_nxt.load = 1'b1;
                        end
                        // Back to back: skip resync while repeating
                        if (s_r.cfg_b[B_REPEAT]) begin
                            s_nxt.state = ACS_ACQ;
                        end else begin
                            s_nxt.state = ACS_IDLE;
                        end
                        s_nxt.cnt = 4'h0;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
            end
            default: begin
                s_nxt.state = ACS_IDLE;
            end
        endcase

        // Pending start set after the case, so a trigger in the start cycle is kept
        if (ext_rise || (s_r.cfg_a[A_TMR_EN] && timer_ovf)) begin
            s_nxt.pend = 1'b1;
        end

        s_nxt.busy = s_nxt.state != ACS_IDLE;
        s_nxt.track = s_nxt.state == ACS_ACQ;
        s_nxt.hold = s_nxt.state == ACS_CONV;

        // One wait cycle per access; write commits when waitrequest is low
        s_nxt.waitreq = 1'b1;
        if ((avs_read || avs_write) && s_r.waitreq) begin
            s_nxt.waitreq = 1'b0;
            s_nxt.rdata = 32'h0;
            case (avs_address)
                OFS_CFG_A: s_nxt.rdata[7:0] = s_r.cfg_a;
                OFS_CFG_B: s_nxt.rdata[7:0] = s_r.cfg_b;
                OFS_CFG_C: s_nxt.rdata[C_BUSY] = s_r.busy;
                OFS_RESULT: s_nxt.rdata[WORD_W-1:0] = s_r.result;
                OFS_TX: s_nxt.rdata[WORD_W-1:0] = s_r.tx_word;
                default: s_nxt.rdata = 32'h0;
            endcase
        end
        // Software write wins over the hardware self-clear in the same cycle
        if (wr_ok) begin
            case (avs_address)
                OFS_CFG_A: s_nxt.cfg_a = avs_writedata[7:0];
                OFS_CFG_B: s_nxt.cfg_b = avs_writedata[7:0];
                default: s_nxt.cfg_a = s_nxt.cfg_a;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.cfg_a <= CFG_A_RST;
            s_r.cfg_b <= CFG_B_RST;
            s_r.state <= ACS_IDLE;
            s_r.ext_prev <= 1'b1;
            s_r.waitreq <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.waitreq;
    assign chan_sel = s_r.cfg_b[B_CHAN_LO +: CHAN_W];
    assign track = s_r.track;
    assign hold_convert = s_r.hold;
    assign conv_tick = tick;
    assign ext_ref_sel = s_r.cfg_a[A_EXT_REF];
    assign busy = s_r.busy;
    assign port3_suspend = s_r.cfg_b[B_FAST];

    a_busy_state: assert property (@(posedge core_clk) disable iff (!rst_n)
        busy == (s_r.state != ACS_IDLE)) else $error("busy flag disagrees with state");

    a_single_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.done && !$past(wr_ok) |-> !s_r.cfg_b[B_SINGLE]) else $error("single shot not cleared");

    a_conv_length: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.state == ACS_CONV && tick && s_r.cnt == CONV_CYCLES - 4'h1 |=> s_r.done) else $error("conversion length wrong");

    a_acq_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.state == ACS_ACQ |-> s_r.cnt <= {2'b00, acq_eff}) else $error("acquisition overran");

    a_temp_force: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_temp |-> div_eff == 2'h3 && acq_eff == 2'h3) else $error("temperature timing not forced");

    a_ext_trigger: assert property (@(posedge core_clk) disable iff (!rst_n)
        ext_rise |=> s_r.pend || s_r.state != ACS_IDLE) else $error("external start lost");

    a_timer_trigger: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.cfg_a[A_TMR_EN] && timer_ovf && s_r.state == ACS_IDLE |=> ##[0:1] s_r.state == ACS_SYNC)
        else $error("timer start lost");

    a_fast_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.done && $past(s_r.cfg_b[B_FAST]) |-> s_r.load ##1 ser_active) else $error("fast capture not sent");

    a_sync_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(s_r.state == ACS_SYNC) |-> ##[1:33] s_r.state == ACS_ACQ) else $error("sync too long");

    a_wait_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");

    a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");

    a_read_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
        !avs_waitrequest |-> avs_readdata[31:WORD_W] == '0)
        else $error("read data upper bits not zero");

    a_tick_space: assert property (@(posedge core_clk) disable iff (!rst_n)
        conv_tick |=> !conv_tick [*3])
        else $error("converter clock pulses too close");

    a_track_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
        track || hold_convert |-> busy)
        else $error("busy low during conversion");

    a_track_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(track && hold_convert))
        else $error("track and hold together");

    a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.state == ACS_IDLE |-> !track && !hold_convert && !busy)
        else $error("idle sequencer not quiet");

    a_start_sw: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.state == ACS_IDLE && (s_r.cfg_b[B_SINGLE] || s_r.cfg_b[B_REPEAT]) |=> s_r.state == ACS_SYNC)
        else $error("software start not taken");

    a_acq_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.state == ACS_SYNC && tick |=> track)
        else $error("acquisition not begun on converter clock");

    a_sync_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.state == ACS_SYNC && !tick |=> s_r.state == ACS_SYNC)
        else $error("sync left without converter clock");

    a_result_data: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.done |-> s_r.result.data == $past(sar_result))
        else $error("result data not captured");

    a_result_chan: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.done |-> s_r.result.chan == $past(chan_sel))
        else $error("result channel not captured");

    a_repeat_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.done && $past(s_r.cfg_b[B_REPEAT]) |-> track)
        else $error("repeat did not continue");

    a_repeat_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.done && !$past(s_r.cfg_b[B_REPEAT]) |-> !busy)
        else $error("conversion ran on without repeat");

    a_load_fast: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.load |-> $past(s_r.cfg_b[B_FAST]))
        else $error("capture load without fast mode");

    a_tx_word: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.load |-> s_r.tx_word == s_r.result)
        else $error("serial word differs from result");

    a_tx_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.load |=> ser_active && ser_mosi == $past(s_r.tx_word.chan[CHAN_W-1]))
        else $error("first serial bit not channel msb");

    a_tx_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_r.load |=> ser_active [*8])
        else $error("serial frame ended early");

    a_sclk_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ser_active |-> !ser_sclk)
        else $error("serial clock runs outside frame");

    a_wr_commit: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(wr_ok && avs_address == OFS_CFG_B) |-> s_r.cfg_b == $past(avs_writedata[7:0]))
        else $error("config B write lost");
endmodule
`default_nettype wire

// ### dv/acs_ser_rx.sv
`timescale 1ns/1ns
`default_nettype none
module acs_ser_rx (
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic [15:0] word,
    output int n_words
);
    logic [15:0] sh;
    int bits;
    // Shift in on sclk rise, first bit lands on top
    always @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            bits = 0;
            n_words = 0;
            sh = '0;
            word = '0;
        end else begin
            sh = {sh[14:0], mosi};
            bits++;
            if (bits == 16) begin
                word = sh;
                n_words++;
                bits = 0;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/acs_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer_tb;
    import acs_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic ext_start_n = 1'b1;
    logic timer_ovf = 1'b0;
    logic [DATA_W-1:0] sar_result = '0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, track, hold_convert, conv_tick, ext_ref_sel, busy, port3_suspend, ser_sclk, ser_mosi, ser_active;
    logic [CHAN_W-1:0] chan_sel;
    logic [15:0] rx_word;
    int rx_n, gap, gap_c;
    int failures = 0;
    int n_compared = 0;
    int ratio[4] = '{8, 4, 16, 32};

    always #25 core_clk = ~core_clk;

    acs_sequencer u_dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_start_n(ext_start_n),
        .timer_ovf(timer_ovf), .sar_result(sar_result), .chan_sel(chan_sel), .track(track),
        .hold_convert(hold_convert), .conv_tick(conv_tick), .ext_ref_sel(ext_ref_sel), .busy(busy),
        .port3_suspend(port3_suspend), .ser_sclk(ser_sclk), .ser_mosi(ser_mosi), .ser_active(ser_active));
    acs_ser_rx u_rx (.rst_n(rst_n), .sclk(ser_sclk), .mosi(ser_mosi), .word(rx_word), .n_words(rx_n));

    // Cycles between converter clock pulses
    always @(posedge core_clk) begin
        gap_c <= conv_tick ? 1 : gap_c + 1;
        if (conv_tick) begin
            gap <= gap_c;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            failures++;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wait_busy(input logic v, input int lim);
        int n;
        n = 0;
        while (busy !== v && n < lim) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    task automatic measure(input int acq_c, input int cnv_c, input int r);
        int n;
        n = 0;
        while (track !== 1'b1 && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        check("busy", busy, 1'b1);
        n = 0;
        while (track === 1'b1) begin
            @(posedge core_clk);
            n++;
        end
        check("acq_cycles", 32'(n), 32'(acq_c));
        n = 0;
        while (hold_convert === 1'b1) begin
            @(posedge core_clk);
            n++;
        end
        check("conv_cycles", 32'(n), 32'(cnv_c));
        check("tick_gap", 32'(gap), 32'(r));
    endtask

    // Low pulse of three cycles, 150 ns, start must wait for the rise
    task automatic ext_pulse;
        @(posedge core_clk);
        ext_start_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("busy_low_phase", busy, 1'b0);
        ext_start_n <= 1'b1;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b0, OFS_CFG_A, 0);
        check("cfg_a_rst", rd, {24'h0, CFG_A_RST});
        bus(1'b0, OFS_CFG_B, 0);
        check("cfg_b_rst", rd, {24'h0, CFG_B_RST});
        bus(1'b0, 8'h40, 0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, OFS_CFG_C, 32'hff);
        bus(1'b0, OFS_CFG_C, 0);
        check("cfg_c_idle", rd, 32'h0);
        bus(1'b1, OFS_CFG_A, 32'h40);
        repeat (2) @(posedge core_clk);
        check("ext_ref_sel", ext_ref_sel, 1'b1);
        // Lane 0 disabled: the write must leave config A untouched
        avs_byteenable <= 4'h0;
        bus(1'b1, OFS_CFG_A, 32'h0);
        avs_byteenable <= 4'hf;
        bus(1'b0, OFS_CFG_A, 0);
        check("byteenable_off", rd, 32'h40);
        for (int i = 0; i < 4; i++) begin
            sar_result <= 12'(256 + i);
            bus(1'b1, OFS_CFG_A, 32'((i << A_DIV_LO) | (i << A_ACQ_LO)));
            bus(1'b1, OFS_CFG_B, 32'h10);
            measure((i + 1) * ratio[i], 15 * ratio[i], ratio[i]);
            wait_busy(1'b0, 100);
            bus(1'b0, OFS_CFG_B, 0);
            check("single_clear", rd, 32'h0);
            bus(1'b0, OFS_RESULT, 0);
            check("result", rd, 32'(256 + i));
        end
        // Temperature channel overrides divide 4 and one acquisition cycle
        bus(1'b1, OFS_CFG_A, 32'h10);
        bus(1'b1, OFS_CFG_B, 32'h18);
        @(posedge core_clk);
        check("chan_sel", chan_sel, TEMP_CHAN);
        measure(4 * 32, 15 * 32, 32);
        wait_busy(1'b0, 100);
        bus(1'b1, OFS_CFG_B, 32'h0);
        bus(1'b1, OFS_CFG_A, 32'h0);
        ext_pulse();
        wait_busy(1'b1, 100);
        check("ext_disabled", busy, 1'b0);
        bus(1'b1, OFS_CFG_A, 32'h1);
        ext_pulse();
        wait_busy(1'b1, 100);
        check("ext_start", busy, 1'b1);
        wait_busy(1'b0, 400);
        bus(1'b1, OFS_CFG_A, 32'h2);
        @(posedge core_clk);
        timer_ovf <= 1'b1;
        @(posedge core_clk);
        timer_ovf <= 1'b0;
        wait_busy(1'b1, 100);
        check("timer_start", busy, 1'b1);
        wait_busy(1'b0, 400);
        // Divide 16 leaves the shifter ample time within each conversion
        bus(1'b1, OFS_CFG_A, 32'h20);
        sar_result <= 12'hc3a;
        bus(1'b1, OFS_CFG_B, 32'h45);
        repeat (2) @(posedge core_clk);
        check("port3_suspend", port3_suspend, 1'b1);
        bus(1'b1, OFS_CFG_B, 32'h65);
        for (int n = 0; n < 1500 && rx_n < 3; n++) @(posedge core_clk);
        check("words_sent", 32'(rx_n), 32'h3);
        check("ser_active", ser_active, 1'b1);
        check("tx_word", rx_word, 16'h5c3a);
        // Result read while the next conversion runs, before it completes
        bus(1'b0, OFS_RESULT, 0);
        check("repeat_result", rd, 32'h5c3a);
        bus(1'b0, OFS_TX, 0);
        check("tx_register", rd, 32'h5c3a);
        bus(1'b1, OFS_CFG_B, 32'h5);
        wait_busy(1'b0, 400);
        check("repeat_stop", busy, 1'b0);
        check("port3_release", port3_suspend, 1'b0);
        check("ser_idle", ser_active, 1'b0);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
